// file: rtl/fws_cycle.sv
// fws_cycle: one asynchronous read or write cycle on the flash pins
// assumes the flash meets its access time within the read count
`timescale 1ns/1ns
module fws_cycle
  import fws_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // request
  input  wire logic       rd_req,
  input  wire logic       wr_req,
  input  wire logic [7:0] wr_data,
  output logic            done,
  output logic [7:0]      rd_data,
  // flash pins (data already synchronised)
  input  wire logic [7:0] dq_in,
  output logic [7:0]      dq_out,
  output logic            dq_oe,
  output logic            oe_n,
  output logic            we_n
);
  fws_bus_type st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  rd_q, rd_d;
  logic [7:0]  wd_q, wd_d;
  logic        done_q, done_d;

  function automatic logic [3:0] cyc(input int n);
    return n[3:0];
  endfunction : cyc

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    rd_d   = rd_q;
    wd_d   = wd_q;
    done_d = 1'b0;
    case (st_q)
      FWS_IDLE: begin
        if (rd_req) begin
          st_d  = FWS_RD_LOW;
          cnt_d = cyc(READ_CYC + 2);
        end else if (wr_req) begin
          st_d  = FWS_WR_LOW;
          wd_d  = wr_data;
          cnt_d = cyc(WRITE_CYC);
        end
      end
      // extra cycles cover the two-stage input synchroniser
      FWS_RD_LOW: begin
        if (cnt_q == 4'h0) begin
          rd_d = dq_in;
          st_d = FWS_GAP;
          cnt_d = cyc(IDLE_CYC);
        end else cnt_d = cnt_q - 4'h1;
      end
      FWS_WR_LOW: begin
        if (cnt_q == 4'h0) begin
          st_d  = FWS_WR_HOLD;
          cnt_d = cyc(IDLE_CYC);
        end else cnt_d = cnt_q - 4'h1;
      end
      FWS_WR_HOLD: begin
        if (cnt_q == 4'h0) begin
          st_d   = FWS_IDLE;
          done_d = 1'b1;
        end else cnt_d = cnt_q - 4'h1;
      end
      // oe high between reads so every read is a distinct cycle
      FWS_GAP: begin
        if (cnt_q == 4'h0) begin
          st_d   = FWS_IDLE;
          done_d = 1'b1;
        end else cnt_d = cnt_q - 4'h1;
      end
      default: st_d = FWS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= FWS_IDLE;
      cnt_q  <= 4'h0;
      rd_q   <= 8'h00;
      wd_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      rd_q   <= rd_d;
      wd_q   <= wd_d;
      done_q <= done_d;
    end
  end

  assign done    = done_q;
  assign rd_data = rd_q;
  assign oe_n    = (st_q != FWS_RD_LOW);
  assign we_n    = (st_q != FWS_WR_LOW);
  assign dq_oe   = (st_q == FWS_WR_LOW) || (st_q == FWS_WR_HOLD);
  assign dq_out  = wd_q;
endmodule : fws_cycle

// file: rtl/fws_pkg.sv
// fws_pkg: shared constants for the flash status-polling controller
// assumes a parallel nor flash with status bits on the low data byte
package fws_pkg;
  // ----------------------------------------------------------------
  // status bit positions on the data byte
  // ----------------------------------------------------------------
  localparam int DATA_POLL_POS    = 7;
  localparam int TOGGLE_ONE_POS   = 6;
  localparam int TIMEOUT_FAIL_POS = 5;
  localparam int ERASE_TIMER_POS  = 3;
  localparam int TOGGLE_TWO_POS   = 2;
  // ----------------------------------------------------------------
  // flash command data
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CMD = 8'hf0;
  // ----------------------------------------------------------------
  // axi register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] EXPECT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] DATA_OFS   = 8'h10;
  // ctrl bits
  localparam int CTRL_GO_POS     = 0;
  localparam int CTRL_MODE_POS   = 1;
  localparam int CTRL_ERASE_POS  = 2;
  // status bits
  localparam int ST_BUSY_POS = 0;
  localparam int ST_DONE_POS = 1;
  localparam int ST_FAIL_POS = 2;
  localparam int ST_RDY_POS  = 3;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int READ_NS     = 100;
  localparam int READ_CYC    = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_NS    = 60;
  localparam int WRITE_CYC   = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_NS     = 40;
  localparam int IDLE_CYC    = (IDLE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    FWS_IDLE, FWS_RD_LOW, FWS_RD_HOLD, FWS_GAP, FWS_WR_LOW, FWS_WR_HOLD
  } fws_bus_type;
endpackage : fws_pkg

// file: rtl/fws_poll.sv
// fws_poll: host controller polling program/erase status of a nor flash
// assumes software issued the command sequence; axi4-lite slave for orders
// How it works
// R1: device drives complement of programmed bit7
// R2: poll at the programmed address
// R3: protected program: status about 1 us
// R4: erase drives poll bit low, then high
// R5: erase polled inside a selected sector
// R6: all-protected erase: status about 100 us
// R7: partly protected erase skips protected sectors
// R8: array data valid from next read
// R9: re-read poll bit after fail bit
// R10: ready_busy_n low while busy
// R11: status valid after last write pulse
// R12: toggle bit one inverts each read
// R13: toggle valid during erase time-out
// R14: erase suspend stops toggle bit one
// R15: suspend-program toggles until done
// R16: protected program toggles about 1 us
// R17: toggle bit two inverts in erasing sectors
// R18: reads delimited by oe or ce
// R19: read twice, compare toggle bit
// R20: fail bit high: recheck, else reset
// R21: resumed polling restarts from first step
// R22: device sets fail bit on limit
// R23: reset command is f0 at any address
// R24: idle device returns array data
`timescale 1ns/1ns
module fws_poll
  import fws_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  // axi4-lite write channels
  input  wire logic              S_AWVALID,
  output logic                   S_AWREADY,
  input  wire logic [7:0]        S_AWADDR,
  input  wire logic              S_WVALID,
  output logic                   S_WREADY,
  input  wire logic [31:0]       S_WDATA,
  input  wire logic [3:0]        S_WSTRB,
  output logic                   S_BVALID,
  input  wire logic              S_BREADY,
  output logic [1:0]             S_BRESP,
  // axi4-lite read channels
  input  wire logic              S_ARVALID,
  output logic                   S_ARREADY,
  input  wire logic [7:0]        S_ARADDR,
  output logic                   S_RVALID,
  input  wire logic              S_RREADY,
  output logic [31:0]            S_RDATA,
  output logic [1:0]             S_RRESP,
  // flash pins
  output logic [ADDR_W-1:0]      FL_ADDR,
  input  wire logic [7:0]        FL_DQ_IN,
  output logic [7:0]             FL_DQ_OUT,
  output logic                   FL_DQ_OE,
  output logic                   FL_CE_N,
  output logic                   FL_OE_N,
  output logic                   FL_WE_N,
  input  wire logic              FL_READY_BUSY_N
);
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
    $error("fws_poll: bad ADDR_W");
  end

  typedef enum logic [2:0] {
    P_IDLE, P_READ1, P_READ2, P_CHECK, P_RECHECK, P_RESET, P_FINAL
  } fws_poll_type;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] dq_s1_q, dq_s2_q;
  logic       rb_s1_q, rb_s2_q;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= FL_DQ_IN;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= FL_READY_BUSY_N;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // bus cycle engine
  // ----------------------------------------------------------------
  logic       cyc_rd, cyc_wr, cyc_done, oe_n_c, we_n_c, dq_oe_c;
  logic [7:0] cyc_data, dq_out_c;
  fws_cycle u_cycle (
    .clk     (MCLK),
    .rst     (SYS_RST),
    .rd_req  (cyc_rd),
    .wr_req  (cyc_wr),
    .wr_data (RESET_CMD),
    .done    (cyc_done),
    .rd_data (cyc_data),
    .dq_in   (dq_s2_q),
    .dq_out  (dq_out_c),
    .dq_oe   (dq_oe_c),
    .oe_n    (oe_n_c),
    .we_n    (we_n_c)
  );

  // ----------------------------------------------------------------
  // registers and polling state
  // ----------------------------------------------------------------
  fws_poll_type st_q, st_d;
  logic [31:0]  addr_q, addr_d;
  logic [7:0]   exp_q, exp_d, first_q, first_d, data_q, data_d;
  logic         mode_q, mode_d, erase_q, erase_d;
  logic         busy_q, busy_d, ok_q, ok_d, fail_q, fail_d;
  logic         awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
  logic         arr_q, arr_d, rv_q, rv_d;
  logic [31:0]  rdata_q, rdata_d;
  logic [1:0]   rresp_q, rresp_d, bresp_q, bresp_d;
  logic         rd_go, wr_go;

  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b,
                                   input logic two);
    return (a[TOGGLE_ONE_POS] ^ b[TOGGLE_ONE_POS]) |
           (two & (a[TOGGLE_TWO_POS] ^ b[TOGGLE_TWO_POS]));
  endfunction : toggled

  assign wr_go  = S_AWVALID && S_WVALID && !bv_q;
  assign rd_go  = S_ARVALID && !rv_q;
  assign cyc_rd = (st_q == P_READ1 || st_q == P_READ2 ||
                   st_q == P_RECHECK || st_q == P_FINAL) && !cyc_done;
  // R23: reset command f0
  assign cyc_wr = (st_q == P_RESET) && !cyc_done;

  always_comb begin
    st_d = st_q;  addr_d = addr_q;  exp_d = exp_q;  first_d = first_q;
    data_d = data_q;  mode_d = mode_q;  erase_d = erase_q;
    busy_d = busy_q;  ok_d = ok_q;  fail_d = fail_q;
    awr_d = 1'b0;  wr_d = 1'b0;  bv_d = bv_q;  bresp_d = bresp_q;
    arr_d = 1'b0;  rv_d = rv_q;  rdata_d = rdata_q;  rresp_d = rresp_q;
    if (bv_q && S_BREADY) bv_d = 1'b0;
    if (rv_q && S_RREADY) rv_d = 1'b0;
    if (wr_go && !awr_q) begin
      awr_d = 1'b1;
      wr_d  = 1'b1;
    end
    if (awr_q) begin
      bv_d    = 1'b1;
      bresp_d = 2'b00;
      case (S_AWADDR)
        CTRL_OFS: begin
          // R21: a go accepted while not busy restarts from first read
          if (S_WSTRB[0] && S_WDATA[CTRL_GO_POS] && !busy_q) begin
            mode_d  = S_WDATA[CTRL_MODE_POS];
            erase_d = S_WDATA[CTRL_ERASE_POS];
            busy_d  = 1'b1;
            ok_d    = 1'b0;
            fail_d  = 1'b0;
            st_d    = P_READ1;
          end
        end
        // R2: R5: poll address supplied by software
        ADDR_OFS: if (!busy_q) addr_d = S_WDATA;
        EXPECT_OFS: if (!busy_q && S_WSTRB[0]) exp_d = S_WDATA[7:0];
        STATUS_OFS, DATA_OFS: ;
        default: bresp_d = 2'b10;
      endcase
    end
    if (rd_go && !arr_q) begin
      arr_d   = 1'b1;
      rv_d    = 1'b1;
      rresp_d = 2'b00;
      case (S_ARADDR)
        CTRL_OFS:   rdata_d = {29'h0, erase_q, mode_q, 1'b0};
        ADDR_OFS:   rdata_d = addr_q;
        EXPECT_OFS: rdata_d = {24'h0, exp_q};
        STATUS_OFS: begin
          rdata_d = STATUS_RST;
          rdata_d[ST_BUSY_POS] = busy_q;
          rdata_d[ST_DONE_POS] = ok_q;
          rdata_d[ST_FAIL_POS] = fail_q;
          // R10: busy pin level
          rdata_d[ST_RDY_POS]  = rb_s2_q;
        end
        DATA_OFS:   rdata_d = {24'h0, data_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = 2'b10;
        end
      endcase
    end
    case (st_q)
      P_IDLE: ;
      P_READ1: if (cyc_done) begin
        first_d = cyc_data;
        st_d    = mode_q ? P_READ2 : P_CHECK;
        data_d  = cyc_data;
      end
      // R19: second read for comparison
      P_READ2: if (cyc_done) begin
        data_d = cyc_data;
        st_d   = P_CHECK;
      end
      P_CHECK: begin
        if (mode_q) begin
          if (!toggled(first_q, data_q, erase_q)) st_d = P_FINAL;
          // R20: fail bit seen, recheck toggling
          else if (data_q[TIMEOUT_FAIL_POS]) st_d = P_RECHECK;
          else begin
            first_d = data_q;
            st_d    = P_READ2;
          end
        end else begin
          // R1: R4: poll bit true means done
          if (data_q[DATA_POLL_POS] == exp_q[DATA_POLL_POS]) st_d = P_FINAL;
          // R9: fail bit, read poll bit again
          else if (data_q[TIMEOUT_FAIL_POS]) st_d = P_RECHECK;
          else st_d = P_READ1;
        end
      end
      P_RECHECK: if (cyc_done) begin
        if (mode_q ? !toggled(data_q, cyc_data, erase_q)
                   : cyc_data[DATA_POLL_POS] == exp_q[DATA_POLL_POS])
          st_d = P_FINAL;
        else st_d = P_RESET;
      end
      P_RESET: if (cyc_done) begin
        fail_d = 1'b1;
        busy_d = 1'b0;
        st_d   = P_IDLE;
      end
      // R8: array data taken from a fresh read
      P_FINAL: if (cyc_done) begin
        data_d = cyc_data;
        ok_d   = 1'b1;
        busy_d = 1'b0;
        st_d   = P_IDLE;
      end
      default: st_d = P_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_q <= P_IDLE;  addr_q <= 32'h0;  exp_q <= 8'h00;
      first_q <= 8'h00;  data_q <= 8'h00;  mode_q <= 1'b0;
      erase_q <= 1'b0;  busy_q <= 1'b0;  ok_q <= 1'b0;  fail_q <= 1'b0;
      awr_q <= 1'b0;  wr_q <= 1'b0;  bv_q <= 1'b0;  bresp_q <= 2'b00;
      arr_q <= 1'b0;  rv_q <= 1'b0;  rdata_q <= 32'h0;  rresp_q <= 2'b00;
      FL_ADDR <= '0;  FL_DQ_OUT <= 8'h00;  FL_DQ_OE <= 1'b0;
      FL_CE_N <= 1'b1;  FL_OE_N <= 1'b1;  FL_WE_N <= 1'b1;
    end else begin
      st_q <= st_d;  addr_q <= addr_d;  exp_q <= exp_d;
      first_q <= first_d;  data_q <= data_d;  mode_q <= mode_d;
      erase_q <= erase_d;  busy_q <= busy_d;  ok_q <= ok_d;
      fail_q <= fail_d;  awr_q <= awr_d;  wr_q <= wr_d;  bv_q <= bv_d;
      bresp_q <= bresp_d;  arr_q <= arr_d;  rv_q <= rv_d;
      rdata_q <= rdata_d;  rresp_q <= rresp_d;
      // R18: ce held low, oe delimits each read
      FL_ADDR <= addr_q[ADDR_W-1:0];
      FL_DQ_OUT <= dq_out_c;
      FL_DQ_OE <= dq_oe_c;
      FL_CE_N <= !busy_q;
      FL_OE_N <= oe_n_c;
      FL_WE_N <= we_n_c;
    end
  end

  assign S_AWREADY = awr_q;
  assign S_WREADY  = wr_q;
  assign S_BVALID  = bv_q;
  assign S_BRESP   = bresp_q;
  assign S_ARREADY = arr_q;
  assign S_RVALID  = rv_q;
  assign S_RDATA   = rdata_q;
  assign S_RRESP   = rresp_q;
endmodule : fws_poll

// file: testbench/fws_flash_model.sv
// fws_flash_model: behavioural nor flash reporting operation status
// assumes the bench starts each embedded operation with a go pulse
`timescale 1ns/1ns
module fws_flash_model (
  // flash pins
  input wire logic [7:0] dq_i,
  input wire logic       ce_n,
  input wire logic       oe_n,
  input wire logic       we_n,
  output logic [7:0]     dq_o,
  output logic           rb_n,
  // bench control
  input wire logic       go,
  input wire logic       erase,
  input wire logic       fail,
  input wire logic       prot,
  input wire logic       susp,
  input wire logic [7:0] pdat,
  input wire logic [7:0] nrd,
  output logic [7:0]     n_f0
);
  import fws_pkg::*;
  logic       busy, tog, bad;
  logic [7:0] left, last, arr;
  initial begin
    busy = 0; tog = 0; bad = 0; left = 0; last = 0; arr = 8'hff; n_f0 = 0;
  end
  // status valid right after the command
  always @(posedge go) begin
    busy = 1; bad = 0; left = nrd;
  end
  // toggling starts at the first read, erase time-out included
  always @(negedge oe_n) if (!ce_n) begin
    if (busy && left == 0 && !fail) begin
      busy = 0;
      // protected target ends with contents untouched
      if (!prot) arr = erase ? 8'hff : pdat;
    end
    // suspended erase: poll bit high, toggle one frozen
    if (busy && erase && susp) last = {1'b1, tog, 3'h0, ~last[2], 2'b00};
    else if (busy) begin
      tog = ~tog;
      if (left != 0) left = left - 8'h01;
      else bad = 1;
      last = {erase ? 1'b0 : ~pdat[7], tog, bad, 1'b0, erase,
              erase & tog, 2'b00};
    end else last = arr;
  end
  // reset command leaves the failed state
  always @(posedge we_n) if (!ce_n && dq_i == RESET_CMD) begin
    busy = 0; bad = 0; n_f0 = n_f0 + 8'h01;
  end
  // released bus drives the complement of the last byte; no pull-up level
  assign dq_o = oe_n ? ~last : last;
  assign rb_n = (busy && !(erase && susp)) ? 1'b0 : 1'b1;
endmodule : fws_flash_model

// file: testbench/fws_poll_asserts.sv
// fws_poll_asserts: port checker for the status-polling controller
// assumes it is bound to fws_poll and sees only its ports
`timescale 1ns/1ns
module fws_poll_asserts
  import fws_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input wire logic              MCLK,
  input wire logic              SYS_RST,
  // axi handshakes
  input wire logic              S_AWREADY,
  input wire logic              S_WREADY,
  input wire logic              S_BVALID,
  input wire logic              S_BREADY,
  input wire logic              S_ARREADY,
  input wire logic              S_RVALID,
  input wire logic              S_RREADY,
  input wire logic [31:0]       S_RDATA,
  // flash pins
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [7:0]        FL_DQ_OUT,
  input wire logic              FL_DQ_OE,
  input wire logic              FL_CE_N,
  input wire logic              FL_OE_N,
  input wire logic              FL_WE_N
);
  import fws_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------------------------------
  // flash cycle shapes and axi handshakes
  // ----------------------------------------------------------------
  // write counter runs from the count down to zero: four low cycles
  sequence we_pulse; !FL_WE_N[*4] ##1 FL_WE_N; endsequence
  sequence rd_gap; FL_OE_N[*2]; endsequence
  rst_idle_a: assert property (disable iff (1'b0) SYS_RST |=> FL_CE_N
    && FL_OE_N && FL_WE_N && !FL_DQ_OE && !S_BVALID && !S_RVALID)
    else $error("pins not idle after reset");
  we_len_a: assert property ($fell(FL_WE_N) |-> we_pulse)
    else $error("write pulse length wrong");
  reset_cmd_a: assert property (
    !FL_WE_N |-> FL_DQ_OE && FL_DQ_OUT == RESET_CMD)
    else $error("write not carrying reset command");
  rd_gap_a: assert property ($rose(FL_OE_N) |-> rd_gap)
    else $error("reads not separated");
  rd_len_a: assert property ($fell(FL_OE_N) |-> !FL_OE_N[*8])
    else $error("read strobe too short");
  rd_clean_a: assert property (
    !FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE)
    else $error("read overlaps write or deselect");
  addr_hold_a: assert property (
    !FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR))
    else $error("poll address moved mid operation");
  aw_w_a: assert property (S_AWREADY |-> S_WREADY ##1 S_BVALID)
    else $error("write accept or response out of step");
  b_hold_a: assert property (S_BVALID && !S_BREADY |=> S_BVALID)
    else $error("bvalid dropped early");
  r_hold_a: assert property (S_RVALID && !S_RREADY
    |=> S_RVALID && $stable(S_RDATA))
    else $error("read answer not held");
  ar_r_a: assert property (S_ARREADY |-> S_RVALID)
    else $error("read accept without data");
endmodule : fws_poll_asserts
bind fws_poll fws_poll_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .S_AWREADY(S_AWREADY),
  .S_WREADY(S_WREADY), .S_BVALID(S_BVALID), .S_BREADY(S_BREADY),
  .S_ARREADY(S_ARREADY), .S_RVALID(S_RVALID), .S_RREADY(S_RREADY),
  .S_RDATA(S_RDATA), .FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT),
  .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N),
  .FL_WE_N(FL_WE_N));

// file: testbench/fws_poll_tb_top.sv
// fws_poll_tb_top: self-checking bench for the status-polling controller
// assumes fws_flash_model on the pins and axi4-lite orders from tasks
`timescale 1ns/1ns
module fws_poll_tb_top;
  import fws_pkg::*;
  logic clk, rst, awv, awrdy, wv, wrdy, bv, br, arv, arrdy, rv, rr;
  logic dqoe, ce_n, oe_n, we_n, rb_n, go, erase, fail, prot, susp;
  logic [7:0]  awa, ara, dq_w, dq_m, dqo, pdat, nrd, n_f0, nf0, arr_e;
  logic [31:0] wd, rd, got, r;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  logic [19:0] fa;
  logic [33:0] notes[$];
  integer seed;
  int n_fail, total_checks;
  fws_poll #(.ADDR_W(20)) dut (.MCLK(clk), .SYS_RST(rst),
    .S_AWVALID(awv), .S_AWREADY(awrdy), .S_AWADDR(awa), .S_WVALID(wv),
    .S_WREADY(wrdy), .S_WDATA(wd), .S_WSTRB(ws), .S_BVALID(bv),
    .S_BREADY(br), .S_BRESP(bresp), .S_ARVALID(arv), .S_ARREADY(arrdy),
    .S_ARADDR(ara), .S_RVALID(rv), .S_RREADY(rr), .S_RDATA(rd),
    .S_RRESP(rresp), .FL_ADDR(fa), .FL_DQ_IN(dq_w), .FL_DQ_OUT(dqo),
    .FL_DQ_OE(dqoe), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
    .FL_READY_BUSY_N(rb_n));
  fws_flash_model u_flash (.dq_i(dq_w), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .dq_o(dq_m), .rb_n(rb_n), .go(go), .erase(erase),
    .fail(fail), .prot(prot), .susp(susp), .pdat(pdat), .nrd(nrd),
    .n_f0(n_f0));
  assign dq_w = dqoe ? dqo : dq_m;
  always #10 clk = ~clk;
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    // a note never answered is a missed result
    while (notes.size() > 0) chk(34'h3_0000_0000, notes.pop_front());
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bound(input int k, input int n);
    if (k >= n) begin
      n_fail++;
      give_verdict();
    end
  endtask : bound
  always @(posedge clk)
    if (rv === 1'b1 && rr === 1'b1 && notes.size() > 0)
      chk({rresp, rd}, notes.pop_front());
  // ----------------------------------------------------------------
  // axi4-lite master
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    int k;
    logic ad, wdn;
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    k = 0;
    ad = 1'b0;
    wdn = 1'b0;
    // bready rises once both items are taken, never twice in one step
    do begin
      @(posedge clk);
      k++;
      if (awrdy === 1'b1) begin
        awv <= 1'b0;
        ad = 1'b1;
      end
      if (wrdy === 1'b1) begin
        wv <= 1'b0;
        wdn = 1'b1;
      end
      if (ad && wdn && br !== 1'b1) br <= 1'b1;
    end while (!(bv === 1'b1 && br === 1'b1) && k < 200);
    br <= 1'b0;
    bound(k, 200);
    chk({32'h0, bresp}, {32'h0, e});
    // one idle edge so the next call does not drive over this release
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e,
                        input logic c);
    int k;
    if (c) notes.push_back(e);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (arrdy === 1'b1) arv <= 1'b0;
    end while (!(rv === 1'b1 && rr === 1'b1) && k < 100);
    got = rd;
    rr <= 1'b0;
    bound(k, 100);
    @(posedge clk);
  endtask : axi_rd
  task automatic run_op(input logic [7:0] d, input logic er,
                        input logic md, input logic fl);
    int k;
    pdat <= d; erase <= er; fail <= fl; nrd <= 8'd2 + d[1:0];
    @(posedge clk); go <= 1;
    @(posedge clk); go <= 0;
    axi_wr(ADDR_OFS, {12'h0, r[27:8]}, 2'b00);
    axi_wr(EXPECT_OFS, er ? 32'h80 : {24'h0, d}, 2'b00);
    axi_wr(CTRL_OFS, {29'h0, er & md, md, 1'b1}, 2'b00);
    axi_rd(STATUS_OFS, {30'h0, susp, 3'h1}, 1);
    k = 0;
    do begin axi_rd(STATUS_OFS, 0, 0); k++; end
    while (got[0] !== 1'b0 && k < 300);
    bound(k, 300);
    nf0 = nf0 + fl;
    chk({14'h0, fa}, {14'h0, r[27:8]});
    axi_rd(STATUS_OFS, fl ? 34'hc : 34'ha, 1);
    if (!fl && !prot && !susp) arr_e = er ? 8'hff : d;
    if (!fl && !susp) axi_rd(DATA_OFS, {26'h0, arr_e}, 1);
    chk({26'h0, n_f0}, {26'h0, nf0});
  endtask : run_op
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst = 1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; go = 0;
    erase = 0; fail = 0; awa = 0; ara = 0; wd = 0; ws = 0; pdat = 0;
    nrd = 0; nf0 = 0; seed = 32'h2bd0; n_fail = 0; total_checks = 0;
    prot = 0; susp = 0; arr_e = 8'hff;
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    axi_rd(STATUS_OFS, 34'h8, 1);
    axi_rd(8'h20, {2'b10, 32'h0}, 1);
    axi_wr(8'h24, 32'h1, 2'b10);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      run_op(r[7:0], i[0], i[1], i[2]);
    end
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    axi_rd(STATUS_OFS, 34'h8, 1);
    run_op(8'h7e, 1'b0, 1'b1, 1'b0);
    prot <= 1'b1;
    run_op(8'h00, 1'b0, 1'b1, 1'b0);
    prot <= 1'b0;
    susp <= 1'b1;
    run_op(8'h00, 1'b1, 1'b0, 1'b0);
    give_verdict();
  end
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule : fws_poll_tb_top
